/* inc/port_stats_pkg.sv */
// Package of constants and types for the port frame statistics block
package port_stats_pkg;
    // -------------------------------------------------------------------
    // Dimensions
    // -------------------------------------------------------------------
    localparam int NUM_PORTS = 16;
    localparam int PORT_W = 4;
    localparam int CNT_W = 32;
    localparam int LEN_W = 11;
    localparam int OCT_W = 11;
    localparam int SEL_W = 6;
    localparam int NUM_CNT = 36;

    // -------------------------------------------------------------------
    // Frame size limits in bytes, and the late collision threshold in bit times
    // -------------------------------------------------------------------
    localparam logic [LEN_W-1:0] MIN_FRAME = 11'h040;
    localparam logic [LEN_W-1:0] MAX_FRAME = 11'h5EE;
    localparam logic [LEN_W-1:0] BIN1_MAX = 11'h07F;
    localparam logic [LEN_W-1:0] BIN2_MAX = 11'h0FF;
    localparam logic [LEN_W-1:0] BIN3_MAX = 11'h1FF;
    localparam logic [LEN_W-1:0] BIN4_MAX = 11'h3FF;
    localparam logic [LEN_W-1:0] LATE_COL_BITS = 11'h200;

    // -------------------------------------------------------------------
    // Counter indices within a port
    // -------------------------------------------------------------------
    localparam logic [SEL_W-1:0] C_RX_FRM = 6'h00;
    localparam logic [SEL_W-1:0] C_RX_MC = 6'h01;
    localparam logic [SEL_W-1:0] C_RX_BC = 6'h02;
    localparam logic [SEL_W-1:0] C_RX_OCT = 6'h03;
    localparam logic [SEL_W-1:0] C_RX_LOST = 6'h04;
    localparam logic [SEL_W-1:0] C_RX_FCS = 6'h05;
    localparam logic [SEL_W-1:0] C_RX_FRMERR = 6'h06;
    localparam logic [SEL_W-1:0] C_RX_UNDER = 6'h07;
    localparam logic [SEL_W-1:0] C_RX_OVER = 6'h08;
    localparam logic [SEL_W-1:0] C_RX_BIN0 = 6'h09;
    localparam logic [SEL_W-1:0] C_RX_FILT = 6'h0F;
    localparam logic [SEL_W-1:0] C_RX_FLOOD = 6'h10;
    localparam logic [SEL_W-1:0] C_TX_FRM = 6'h11;
    localparam logic [SEL_W-1:0] C_TX_MC = 6'h12;
    localparam logic [SEL_W-1:0] C_TX_BC = 6'h13;
    localparam logic [SEL_W-1:0] C_TX_OCT = 6'h14;
    localparam logic [SEL_W-1:0] C_TX_LOST = 6'h15;
    localparam logic [SEL_W-1:0] C_TX_COL = 6'h16;
    localparam logic [SEL_W-1:0] C_TX_SCOL = 6'h17;
    localparam logic [SEL_W-1:0] C_TX_MCOL = 6'h18;
    localparam logic [SEL_W-1:0] C_TX_XCOL = 6'h19;
    localparam logic [SEL_W-1:0] C_TX_BIN0 = 6'h1A;
    localparam logic [SEL_W-1:0] C_TX_DEFER = 6'h20;
    localparam logic [SEL_W-1:0] C_TX_LATE = 6'h21;
    localparam logic [SEL_W-1:0] C_RESERVED0 = 6'h22;

    // Reset value of every counter
    localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;

    // Transmit frame outcome codes
    typedef enum logic [1:0] {
        TX_OK = 2'h0,
        TX_XCOL = 2'h1,
        TX_DROP = 2'h2
    } tx_outcome_t;
endpackage : port_stats_pkg

/* design/port_frame_statistics.sv */
// Per-port receive and transmit frame statistics counters
`timescale 1ns/1ps
`default_nettype none
module port_frame_statistics (
    input wire logic REF_CLK_I,                                  // 100 MHz clock
    input wire logic RST_N_I,                                    // Sync reset, active low
    // Receive frame report
    input wire logic RX_DONE_I,                                  // Frame end pulse
    input wire logic [port_stats_pkg::PORT_W-1:0] RX_PORT_I,     // Receiving port
    input wire logic [port_stats_pkg::LEN_W-1:0] RX_LEN_I,       // Octets incl. FCS
    input wire logic RX_CRC_ERR_I,                               // CRC mismatch
    input wire logic RX_ALIGN_ERR_I,                             // Improper framing
    input wire logic RX_MCAST_I,                                 // Multicast dest
    input wire logic RX_BCAST_I,                                 // Broadcast dest
    input wire logic RX_LOST_I,                                  // Rx buffer overflow
    input wire logic RX_FILTERED_I,                              // Not forwarded
    input wire logic RX_FLOODED_I,                               // Unknown destination
    // Transmit frame report
    input wire logic TX_DONE_I,                                  // Frame end pulse
    input wire logic [port_stats_pkg::PORT_W-1:0] TX_PORT_I,     // Sending port
    input wire logic [port_stats_pkg::LEN_W-1:0] TX_LEN_I,       // Octets incl. FCS
    input wire logic [1:0] TX_OUTCOME_I,                         // tx_outcome_t code
    input wire logic [4:0] TX_COLS_I,                            // Collisions this frame
    input wire logic TX_DEFERRED_I,                              // First try deferred
    input wire logic TX_MCAST_I,                                 // Multicast dest
    input wire logic TX_BCAST_I,                                 // Broadcast dest
    // Collision event report
    input wire logic COL_I,                                      // Collision pulse
    input wire logic [port_stats_pkg::PORT_W-1:0] COL_PORT_I,    // Colliding port
    input wire logic [port_stats_pkg::LEN_W-1:0] COL_BITS_I,     // Bit times sent so far
    // Management
    input wire logic CLR_I,                                      // Clear request pulse
    input wire logic CLR_ALL_I,                                  // Clear every port
    input wire logic [port_stats_pkg::PORT_W-1:0] CLR_PORT_I,    // Port to clear
    input wire logic RD_I,                                       // Read request pulse
    input wire logic [port_stats_pkg::PORT_W-1:0] RD_PORT_I,     // Port to read
    input wire logic [port_stats_pkg::SEL_W-1:0] RD_SEL_I,       // Counter index
    output logic RD_VALID_O,                                     // Read data valid
    output logic [port_stats_pkg::CNT_W-1:0] RD_DATA_O           // Counter value
);

    // -------------------------------------------------------------------
    // Types and state
    // -------------------------------------------------------------------
    localparam int TOTAL = port_stats_pkg::NUM_PORTS * port_stats_pkg::NUM_CNT;

    typedef logic [port_stats_pkg::CNT_W-1:0] cnt_t;
    typedef logic [port_stats_pkg::NUM_CNT-1:0] inc_vec_t;

    typedef struct packed {
        cnt_t [TOTAL-1:0] cnt;
        logic rd_valid;
        cnt_t rd_data;
    } state_t;

    state_t state_ff;
    state_t nxt_state_ff;

    // Length bin index 0..5, or 7 when outside 64..1518
    function automatic logic [2:0] len_bin(input logic [port_stats_pkg::LEN_W-1:0] len);
        logic [2:0] b;
        b = 3'h7;
        if (len == port_stats_pkg::MIN_FRAME) begin
            b = 3'h0;
        end else if (len > port_stats_pkg::MIN_FRAME && len <= port_stats_pkg::BIN1_MAX) begin
            b = 3'h1;
        end else if (len > port_stats_pkg::BIN1_MAX && len <= port_stats_pkg::BIN2_MAX) begin
            b = 3'h2;
        end else if (len > port_stats_pkg::BIN2_MAX && len <= port_stats_pkg::BIN3_MAX) begin
            b = 3'h3;
        end else if (len > port_stats_pkg::BIN3_MAX && len <= port_stats_pkg::BIN4_MAX) begin
            b = 3'h4;
        end else if (len > port_stats_pkg::BIN4_MAX && len <= port_stats_pkg::MAX_FRAME) begin
            b = 3'h5;
        end
        return b;
    endfunction : len_bin

    // -------------------------------------------------------------------
    // Per-event increment flags
    // -------------------------------------------------------------------
    inc_vec_t rx_inc;
    inc_vec_t tx_inc;
    inc_vec_t col_inc;
    logic [2:0] rx_bin;
    logic [2:0] tx_bin;
    logic rx_size_ok;
    logic tx_ok;

    // Receive event decode; a lost frame still counts as received
    always_comb begin
        rx_inc = '0;
        rx_bin = len_bin(RX_LEN_I);
        rx_size_ok = (RX_LEN_I >= port_stats_pkg::MIN_FRAME) &&
                     (RX_LEN_I <= port_stats_pkg::MAX_FRAME);
        if (RX_DONE_I) begin
            rx_inc[port_stats_pkg::C_RX_FRM] = 1'b1;
            rx_inc[port_stats_pkg::C_RX_MC] = RX_MCAST_I && !RX_BCAST_I &&
                                              !RX_CRC_ERR_I && !RX_ALIGN_ERR_I;
            rx_inc[port_stats_pkg::C_RX_BC] = RX_BCAST_I && !RX_CRC_ERR_I && !RX_ALIGN_ERR_I;
            rx_inc[port_stats_pkg::C_RX_LOST] = RX_LOST_I;
            rx_inc[port_stats_pkg::C_RX_FCS] = rx_size_ok && RX_CRC_ERR_I && !RX_ALIGN_ERR_I;
            rx_inc[port_stats_pkg::C_RX_FRMERR] = rx_size_ok && RX_CRC_ERR_I && RX_ALIGN_ERR_I;
            rx_inc[port_stats_pkg::C_RX_UNDER] = (RX_LEN_I < port_stats_pkg::MIN_FRAME) &&
                                                 !RX_CRC_ERR_I && !RX_ALIGN_ERR_I;
            rx_inc[port_stats_pkg::C_RX_OVER] = (RX_LEN_I > port_stats_pkg::MAX_FRAME) &&
                                                !RX_CRC_ERR_I && !RX_ALIGN_ERR_I;
            if (rx_bin != 3'h7) begin
                rx_inc[port_stats_pkg::C_RX_BIN0 + 6'(rx_bin)] = 1'b1;
            end
            rx_inc[port_stats_pkg::C_RX_FILT] = RX_FILTERED_I;
            rx_inc[port_stats_pkg::C_RX_FLOOD] = RX_FLOODED_I;
        end
    end

    // Transmit event decode; only TX_OK frames feed the success counts
    always_comb begin
        tx_inc = '0;
        tx_bin = len_bin(TX_LEN_I);
        tx_ok = TX_DONE_I && (TX_OUTCOME_I == port_stats_pkg::TX_OK);
        if (tx_ok) begin
            tx_inc[port_stats_pkg::C_TX_FRM] = 1'b1;
            tx_inc[port_stats_pkg::C_TX_MC] = TX_MCAST_I && !TX_BCAST_I;
            tx_inc[port_stats_pkg::C_TX_BC] = TX_BCAST_I;
            tx_inc[port_stats_pkg::C_TX_SCOL] = (TX_COLS_I == 5'h01);
            tx_inc[port_stats_pkg::C_TX_MCOL] = (TX_COLS_I >= 5'h02);
            tx_inc[port_stats_pkg::C_TX_DEFER] = TX_DEFERRED_I && (TX_COLS_I == 5'h00);
            if (tx_bin != 3'h7) begin
                tx_inc[port_stats_pkg::C_TX_BIN0 + 6'(tx_bin)] = 1'b1;
            end
        end
        tx_inc[port_stats_pkg::C_TX_XCOL] = TX_DONE_I &&
                                            (TX_OUTCOME_I == port_stats_pkg::TX_XCOL);
        tx_inc[port_stats_pkg::C_TX_LOST] = TX_DONE_I &&
                                            (TX_OUTCOME_I == port_stats_pkg::TX_DROP);
    end

    // Collision event decode
    always_comb begin
        col_inc = '0;
        if (COL_I) begin
            col_inc[port_stats_pkg::C_TX_COL] = 1'b1;
            col_inc[port_stats_pkg::C_TX_LATE] = (COL_BITS_I > port_stats_pkg::LATE_COL_BITS);
        end
    end

    // -------------------------------------------------------------------
    // Next state: counters, clear, read port
    // -------------------------------------------------------------------
    always_comb begin
        int idx;
        cnt_t add;
        nxt_state_ff = state_ff;
        idx = 0;
        add = '0;
        for (int p = 0; p < port_stats_pkg::NUM_PORTS; p++) begin
            for (int c = 0; c < port_stats_pkg::NUM_CNT; c++) begin
                idx = p * port_stats_pkg::NUM_CNT + c;
                add = '0;
                if (RX_PORT_I == p[port_stats_pkg::PORT_W-1:0] && rx_inc[c]) begin
                    add = 32'h0000_0001;
                end
                if (TX_PORT_I == p[port_stats_pkg::PORT_W-1:0] && tx_inc[c]) begin
                    add = 32'h0000_0001;
                end
                if (COL_PORT_I == p[port_stats_pkg::PORT_W-1:0] && col_inc[c]) begin
                    add = 32'h0000_0001;
                end
                if (c == int'(port_stats_pkg::C_RX_OCT) && RX_DONE_I &&
                    RX_PORT_I == p[port_stats_pkg::PORT_W-1:0]) begin
                    add = cnt_t'(RX_LEN_I);
                end
                if (c == int'(port_stats_pkg::C_TX_OCT) && tx_ok &&
                    TX_PORT_I == p[port_stats_pkg::PORT_W-1:0]) begin
                    add = cnt_t'(TX_LEN_I);
                end
                nxt_state_ff.cnt[idx] = state_ff.cnt[idx] + add;
                if (CLR_I && (CLR_ALL_I || CLR_PORT_I == p[port_stats_pkg::PORT_W-1:0])) begin
                    nxt_state_ff.cnt[idx] = port_stats_pkg::CNT_RST;
                end
            end
        end
        // Read returns the value before this cycle's update
        nxt_state_ff.rd_valid = RD_I;
        nxt_state_ff.rd_data = '0;
        if (RD_I && RD_SEL_I < port_stats_pkg::C_RESERVED0) begin
            nxt_state_ff.rd_data = state_ff.cnt[int'(RD_PORT_I) * port_stats_pkg::NUM_CNT +
                                                int'(RD_SEL_I)];
        end
    end

    // -------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state_ff;
        end
    end

    // Outputs straight from flip-flops
    assign RD_VALID_O = state_ff.rd_valid;
    assign RD_DATA_O = state_ff.rd_data;

endmodule : port_frame_statistics
`default_nettype wire

/* tb/stats_asserts.sv */
// Port-level checker for the statistics block
`timescale 1ns/1ps
`default_nettype none
module stats_asserts (
    input wire logic REF_CLK_I, // Clock
    input wire logic RST_N_I, // Sync reset
    input wire logic RX_DONE_I, // Rx report
    input wire logic [3:0] RX_PORT_I, // Rx port
    input wire logic TX_DONE_I, // Tx report
    input wire logic COL_I, // Collision
    input wire logic CLR_I, // Clear
    input wire logic CLR_ALL_I, // Clear all
    input wire logic [3:0] CLR_PORT_I, // Clear port
    input wire logic RD_I, // Read
    input wire logic [3:0] RD_PORT_I, // Read port
    input wire logic [5:0] RD_SEL_I, // Read index
    input wire logic RD_VALID_O, // Read valid
    input wire logic [31:0] RD_DATA_O // Read data
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    // No event or clear can disturb a read
    logic quiet;
    assign quiet = RD_I && !RX_DONE_I && !TX_DONE_I && !COL_I && !CLR_I;
    read_answer_a: assert property (RD_I |=> RD_VALID_O) else $error("read not answered");
    idle_valid_a: assert property (!RD_I |=> !RD_VALID_O) else $error("valid without read");
    idle_data_a: assert property (!RD_VALID_O |-> RD_DATA_O == 32'h0) else $error("stale data");
    reset_out_a: assert property (disable iff (1'b0) !RST_N_I |=> !RD_VALID_O && RD_DATA_O == 32'h0)
        else $error("outputs not cleared by reset");
    reserved_sel_a: assert property (RD_I && RD_SEL_I >= port_stats_pkg::C_RESERVED0
        |=> RD_DATA_O == 32'h0) else $error("reserved index not zero");
    clear_all_a: assert property (CLR_I && CLR_ALL_I ##1 quiet |=> RD_DATA_O == 32'h0)
        else $error("counter not zero after clear all");
    clear_port_a: assert property (CLR_I && !CLR_ALL_I ##1 quiet
        && RD_PORT_I == $past(CLR_PORT_I)
        |=> RD_DATA_O == 32'h0) else $error("port not zero after clear");
    // Frame report, one idle cycle, then a quiet read of the frame count
    rx_first_a: assert property (CLR_I && CLR_ALL_I ##1 RX_DONE_I && !CLR_I
        ##1 !RX_DONE_I && !TX_DONE_I && !COL_I && !CLR_I ##1 quiet
        && RD_SEL_I == port_stats_pkg::C_RX_FRM && RD_PORT_I == $past(RX_PORT_I, 2)
        |=> RD_DATA_O == 32'h1) else $error("first frame not counted");
    cover property (RD_I && RD_SEL_I >= port_stats_pkg::C_RESERVED0);
    cover property (CLR_I && CLR_ALL_I);
    cover property (CLR_I && RX_DONE_I);
endmodule : stats_asserts
bind port_frame_statistics stats_asserts stats_asserts_inst (.REF_CLK_I, .RST_N_I, .RX_DONE_I,
    .RX_PORT_I, .TX_DONE_I, .COL_I, .CLR_I, .CLR_ALL_I, .CLR_PORT_I, .RD_I, .RD_PORT_I,
    .RD_SEL_I, .RD_VALID_O, .RD_DATA_O);
`default_nettype wire

/* tb/stats_partner.sv */
// Far-side model: frame pipeline reports and management reader
`timescale 1ns/1ps
`default_nettype none
module stats_partner (
    input wire logic clk_i, // Block clock
    input wire logic vld_i, // Read valid
    input wire logic [31:0] dat_i, // Read data
    output logic [22:0] rx_o, // Done, port, len, crc, align, mc, bc, lost, filt, flood
    output logic [25:0] tx_o, // Done, port, len, outcome, cols, def, mc, bc
    output logic [15:0] col_o, // Pulse, port, bits
    output logic [5:0] clr_o, // Pulse, all, port
    output logic [10:0] rd_o // Pulse, port, sel
);
    // Idle at time zero
    initial begin
        rx_o = '0;
        tx_o = '0;
        col_o = '0;
        clr_o = '0;
        rd_o = '0;
    end
    // One-cycle reports; fields inverted afterwards so stale values never look valid
    // An idle edge follows, except after clr, so back-to-back calls never rewrite a port in one step
    task automatic rx(input logic [3:0] p, input logic [10:0] n, input logic [6:0] f);
        rx_o = {1'b1, p, n, f};
        @(posedge clk_i);
        #1 rx_o = {1'b0, ~p, ~n, ~f};
        @(posedge clk_i);
        #1;
    endtask : rx
    task automatic tx(input logic [3:0] p, input logic [10:0] n, input logic [1:0] o,
        input logic [4:0] c, input logic [2:0] f);
        tx_o = {1'b1, p, n, o, c, f};
        @(posedge clk_i);
        #1 tx_o = {1'b0, ~p, ~n, ~o, ~c, ~f};
        @(posedge clk_i);
        #1;
    endtask : tx
    task automatic col(input logic [3:0] p, input logic [10:0] b);
        col_o = {1'b1, p, b};
        @(posedge clk_i);
        #1 col_o = {1'b0, ~p, ~b};
        @(posedge clk_i);
        #1;
    endtask : col
    task automatic clr(input logic a, input logic [3:0] p);
        clr_o = {1'b1, a, p};
        @(posedge clk_i);
        #1 clr_o = {1'b0, ~a, ~p};
    endtask : clr
    // Answer stands only in the cycle after the request edge, so take it there
    task automatic rd(input logic [3:0] p, input logic [5:0] s, output logic v,
        output logic [31:0] d);
        rd_o = {1'b1, p, s};
        @(posedge clk_i);
        #1 v = vld_i;
        d = dat_i;
        rd_o = {1'b0, ~p, ~s};
        @(posedge clk_i);
        #1;
    endtask : rd
endmodule : stats_partner
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the port statistics counters
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [22:0] rx;
    logic [25:0] tx;
    logic [15:0] cl;
    logic [5:0] cr;
    logic [10:0] rq;
    logic vld;
    logic [31:0] dat;
    int n_mismatch = 0;
    int check_count = 0;
    logic [15:0] ex [17];
    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end
    stats_partner partner_inst (.clk_i(clk), .vld_i(vld), .dat_i(dat), .rx_o(rx), .tx_o(tx),
        .col_o(cl), .clr_o(cr), .rd_o(rq));
    port_frame_statistics port_frame_statistics_inst (.REF_CLK_I(clk), .RST_N_I(rst_n),
        .RX_DONE_I(rx[22]), .RX_PORT_I(rx[21:18]), .RX_LEN_I(rx[17:7]), .RX_CRC_ERR_I(rx[6]),
        .RX_ALIGN_ERR_I(rx[5]), .RX_MCAST_I(rx[4]), .RX_BCAST_I(rx[3]), .RX_LOST_I(rx[2]),
        .RX_FILTERED_I(rx[1]), .RX_FLOODED_I(rx[0]), .TX_DONE_I(tx[25]), .TX_PORT_I(tx[24:21]),
        .TX_LEN_I(tx[20:10]), .TX_OUTCOME_I(tx[9:8]), .TX_COLS_I(tx[7:3]),
        .TX_DEFERRED_I(tx[2]), .TX_MCAST_I(tx[1]), .TX_BCAST_I(tx[0]), .COL_I(cl[15]),
        .COL_PORT_I(cl[14:11]), .COL_BITS_I(cl[10:0]), .CLR_I(cr[5]), .CLR_ALL_I(cr[4]),
        .CLR_PORT_I(cr[3:0]), .RD_I(rq[10]), .RD_PORT_I(rq[9:6]), .RD_SEL_I(rq[5:0]),
        .RD_VALID_O(vld), .RD_DATA_O(dat));
    // Verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask : chk
    // Read one counter, check valid and value
    task automatic rdx(input logic [3:0] p, input logic [5:0] s, input logic [15:0] e);
        logic v;
        logic [31:0] d;
        partner_inst.rd(p, s, v, d);
        chk($sformatf("valid p%0d s%0h", p, s), 32'h1, {31'h0, v});
        chk($sformatf("count p%0d s%0h", p, s), {16'h0, e}, d);
    endtask : rdx
    task automatic test_reset();
        rdx(4'h0, port_stats_pkg::C_RX_FRM, 16'h0);
        rdx(4'hF, port_stats_pkg::C_TX_LATE, 16'h0);
        rdx(4'h2, port_stats_pkg::C_RESERVED0, 16'h0);
        $display("test_reset done");
    endtask : test_reset
    // Mixed receive classes on port 3
    task automatic test_rx();
        partner_inst.clr(1'b1, 4'h0);
        partner_inst.rx(4'h3, 11'h040, 7'h10);
        rdx(4'h3, port_stats_pkg::C_RX_FRM, 16'h1);
        partner_inst.rx(4'h3, 11'h064, 7'h08);
        partner_inst.rx(4'h3, 11'h0C8, 7'h40);
        partner_inst.rx(4'h3, 11'h12C, 7'h60);
        partner_inst.rx(4'h3, 11'h03C, 7'h00);
        partner_inst.rx(4'h3, 11'h640, 7'h00);
        partner_inst.rx(4'h3, 11'h5EE, 7'h07);
        partner_inst.rx(4'h3, 11'h258, 7'h50);
        ex = '{16'h8, 16'h1, 16'h1, 16'h115A, 16'h1, 16'h2, 16'h1, 16'h1, 16'h1,
            16'h1, 16'h1, 16'h1, 16'h1, 16'h1, 16'h1, 16'h1, 16'h1};
        for (int i = 0; i < 17; i++) rdx(4'h3, 6'(i), ex[i]);
        $display("test_rx done");
    endtask : test_rx
    // Transmit outcomes and collisions on port 7
    task automatic test_tx();
        partner_inst.clr(1'b0, 4'h7);
        rdx(4'h7, port_stats_pkg::C_TX_FRM, 16'h0);
        partner_inst.tx(4'h7, 11'h040, port_stats_pkg::TX_OK, 5'h01, 3'h2);
        partner_inst.tx(4'h7, 11'h041, port_stats_pkg::TX_OK, 5'h02, 3'h1);
        partner_inst.tx(4'h7, 11'h080, port_stats_pkg::TX_OK, 5'h00, 3'h4);
        partner_inst.tx(4'h7, 11'h100, port_stats_pkg::TX_OK, 5'h03, 3'h4);
        partner_inst.tx(4'h7, 11'h200, port_stats_pkg::TX_XCOL, 5'h10, 3'h0);
        partner_inst.tx(4'h7, 11'h400, port_stats_pkg::TX_DROP, 5'h00, 3'h0);
        partner_inst.tx(4'h7, 11'h5EE, 2'h3, 5'h00, 3'h0);
        partner_inst.tx(4'h7, 11'h3E8, port_stats_pkg::TX_OK, 5'h00, 3'h0);
        partner_inst.tx(4'h7, 11'h5EE, port_stats_pkg::TX_OK, 5'h00, 3'h0);
        partner_inst.col(4'h7, 11'h200);
        partner_inst.col(4'h7, 11'h201);
        ex = '{16'h6, 16'h1, 16'h1, 16'hBD7, 16'h1, 16'h2, 16'h1, 16'h2, 16'h1,
            16'h1, 16'h1, 16'h1, 16'h1, 16'h1, 16'h1, 16'h1, 16'h1};
        for (int i = 0; i < 17; i++) rdx(4'h7, 6'(i + 17), ex[i]);
        $display("test_tx done");
    endtask : test_tx
    // Clear scope and clear winning over a same-cycle frame
    task automatic test_clear();
        partner_inst.rx(4'h5, 11'h040, 7'h00);
        partner_inst.clr(1'b0, 4'h3);
        rdx(4'h3, port_stats_pkg::C_RX_OCT, 16'h0);
        rdx(4'h5, port_stats_pkg::C_RX_FRM, 16'h1);
        fork
            partner_inst.clr(1'b0, 4'h5);
            partner_inst.rx(4'h5, 11'h040, 7'h00);
        join
        rdx(4'h5, port_stats_pkg::C_RX_FRM, 16'h0);
        partner_inst.clr(1'b1, 4'h0);
        rdx(4'h7, port_stats_pkg::C_TX_OCT, 16'h0);
        $display("test_clear done");
    endtask : test_clear
    // Reset in mid-run clears the counters of port 9
    task automatic test_mid_reset();
        partner_inst.rx(4'h9, 11'h040, 7'h00);
        rdx(4'h9, port_stats_pkg::C_RX_FRM, 16'h1);
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        rdx(4'h9, port_stats_pkg::C_RX_FRM, 16'h0);
        rdx(4'h9, port_stats_pkg::C_RX_OCT, 16'h0);
        $display("test_mid_reset done");
    endtask : test_mid_reset
    // Hang guard
    initial begin
        #200000;
        n_mismatch++;
        results();
    end
    // Main sequence: reset for 16 cycles, then the scenarios
    initial begin
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        test_reset();
        test_rx();
        test_tx();
        test_clear();
        test_mid_reset();
        results();
    end
endmodule : testbench
`default_nettype wire
